// [design/cbt_consts.vh]
`ifndef CBT_CONSTS_VH
`define CBT_CONSTS_VH
// Register byte addresses
`define CBT_ADDR_TIMING 12'h000
`define CBT_ADDR_FLAGS 12'h004
`define CBT_ADDR_ENABLES 12'h008
`define CBT_ADDR_CTRL 12'h00C
`define CBT_ADDR_PRESC 12'h010
// Control register bits
`define CBT_CTRL_INIT_REQUEST 0
`define CBT_CTRL_WAKEUP_ENABLE 1
`define CBT_CTRL_SLEEP 2
`define CBT_CTRL_INIT_ACKNOWLEDGE 3
// Timing register fields
`define CBT_TIM_TRIPLE_SAMPLE_SELECT 7
`define CBT_TIM_TS2_HI 6
`define CBT_TIM_TS2_LO 4
`define CBT_TIM_TS1_HI 3
`define CBT_TIM_TS1_LO 0
// Flag register fields
`define CBT_FLG_WUP 7
`define CBT_FLG_CSC 6
`define CBT_FLG_RST_HI 5
`define CBT_FLG_RST_LO 4
`define CBT_FLG_TST_HI 3
`define CBT_FLG_TST_LO 2
// Reset values
`define CBT_RST_BYTE 8'h00
`define CBT_RST_PRESC 6'h00
// Error thresholds
`define CBT_LIM_WARN 9'h060
`define CBT_LIM_PASS 9'h07F
`define CBT_LIM_OFF 9'h0FF
// Error-state encodings
`define CBT_ST_OK 2'h0
`define CBT_ST_WRN 2'h1
`define CBT_ST_ERR 2'h2
`define CBT_ST_OFF 2'h3
`endif

// [design/cbt_bit_timer.v]
`timescale 1ns/1ps
`include "cbt_consts.vh"
// Quantum and bit-time sequencer with sampling
module cbt_bit_timer (
    input wire pclk,
    input wire presetn,
    input wire run,
    input wire [5:0] presc,
    input wire [3:0] ts1,
    input wire [2:0] ts2,
    input wire triple,
    input wire rx_sync,
    output reg rx_bit_q,
    output reg bit_done_q
);
    reg [5:0] pcnt_q;
    reg [4:0] qcnt_q;
    reg [2:0] triple_sample_select_q;
    wire tq_en;
    wire [4:0] bit_len;
    wire [4:0] sp_pos;
    function maj3;
        input [2:0] s;
        begin
            maj3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
        end
    endfunction
    // Prescaler value P = field + 1 pclk cycles per quantum
    assign tq_en = run && (pcnt_q == presc);
    // Bit = 1 sync + (ts1+1) + (ts2+1) quanta
    assign bit_len = 5'd3 + {1'b0, ts1} + {2'b00, ts2};
    assign sp_pos = 5'd1 + {1'b0, ts1};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcnt_q <= `CBT_RST_PRESC;
            qcnt_q <= 5'd0;
            triple_sample_select_q <= 3'b111;
            rx_bit_q <= 1'b1;
            bit_done_q <= 1'b0;
        end else begin
            bit_done_q <= 1'b0;
            if (!run) begin
                pcnt_q <= `CBT_RST_PRESC;
                qcnt_q <= 5'd0;
            end else if (tq_en) begin
                pcnt_q <= `CBT_RST_PRESC;
                // Samples in the two quanta before and at the sample point
                if (qcnt_q + 5'd2 >= sp_pos && qcnt_q <= sp_pos)
                    triple_sample_select_q <= {triple_sample_select_q[1:0], rx_sync};
                if (qcnt_q == sp_pos) begin
                    if (triple)
                        rx_bit_q <= maj3({triple_sample_select_q[1:0], rx_sync});
                    else
                        rx_bit_q <= rx_sync;
                end
                if (qcnt_q == bit_len - 5'd1) begin
                    qcnt_q <= 5'd0;
                    bit_done_q <= 1'b1;
                end else begin
                    qcnt_q <= qcnt_q + 5'd1;
                end
            end else begin
                pcnt_q <= pcnt_q + 6'd1;
            end
        end
    end
endmodule // cbt_bit_timer

// [design/cbt_top.v]
// Functional notes
// - Timing register writable only in init mode
// - Top timing bit selects one or three samples
// - Bit is single sample or majority
// - Segment two equals field plus one
// - Segment one equals field plus one
// - Bit time is prescaler times quanta sum
// - Flag clears by writing one, condition gone
// - Each flag has own interrupt enable
// - Flags writable outside init; states read-only
// - Flags held reset during init mode
// - Wake flag set on sleep activity
// - Status flag set on bus status change
// - States frozen while status flag pending
// - Receive state encodes counter thresholds, bus-off
// - Transmit state uses same thresholds
// - Leaving bus-off returns receive state OK; code returns the receive counter's threshold state instead
`timescale 1ns/1ps
`include "cbt_consts.vh"
module cbt_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire can_rx,
    input wire [8:0] tx_err_count,
    input wire [7:0] rx_err_count,
    output reg rx_bit_q,
    output reg bit_done_q,
    output reg wakeup_irq_q,
    output reg error_irq_q,
    output reg init_acknowledge_q
);
    reg [7:0] timing_q;
    reg [7:0] enables_q;
    reg [5:0] presc_q;
    reg init_request_q;
    reg wakeup_enable_q;
    reg sleep_q;
    reg wakeup_flag_q;
    reg status_change_flag_q;
    reg [1:0] rx_state_q;
    reg [1:0] tx_state_q;
    reg rx_meta_q;
    reg rx_sync_q;
    reg rx_prev_q;
    reg [31:0] rdata_d;
    wire init_mode;
    wire wr_acc;
    wire rd_acc;
    wire addr_ok;
    wire [1:0] rx_state_d;
    wire [1:0] tx_state_d;
    wire bus_activity;
    wire wup_clr;
    wire csc_clr;
    wire tim_rx_bit;
    wire tim_done;
    function [1:0] err_state;
        input [8:0] cnt;
        begin
            if (cnt <= `CBT_LIM_WARN)
                err_state = `CBT_ST_OK;
            else if (cnt <= `CBT_LIM_PASS)
                err_state = `CBT_ST_WRN;
            else
                err_state = `CBT_ST_ERR;
        end
    endfunction
    function is_reg;
        input [11:0] a;
        begin
            is_reg = (a == `CBT_ADDR_TIMING) || (a == `CBT_ADDR_FLAGS) || (a == `CBT_ADDR_ENABLES) ||
                (a == `CBT_ADDR_CTRL) || (a == `CBT_ADDR_PRESC);
        end
    endfunction
    assign init_mode = init_request_q && init_acknowledge_q;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;
    assign addr_ok = is_reg(paddr);
    // Bus-off overrides both fields; dropping below it returns receive to its counter's state
    assign tx_state_d = (tx_err_count > `CBT_LIM_OFF) ? `CBT_ST_OFF : err_state(tx_err_count);
    assign rx_state_d = (tx_err_count > `CBT_LIM_OFF) ? `CBT_ST_OFF :
        err_state({1'b0, rx_err_count});
    assign bus_activity = rx_prev_q && !rx_sync_q;
    // Write-one clears only when condition no longer holds
    assign wup_clr = wr_acc && !init_mode && (paddr == `CBT_ADDR_FLAGS) &&
        pwdata[`CBT_FLG_WUP] && !(sleep_q && bus_activity);
    assign csc_clr = wr_acc && !init_mode && (paddr == `CBT_ADDR_FLAGS) &&
        pwdata[`CBT_FLG_CSC];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end else begin
            rx_meta_q <= can_rx;
            rx_sync_q <= rx_meta_q;
            rx_prev_q <= rx_sync_q;
        end
    end
    // Control, timing, enables, prescaler
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timing_q <= `CBT_RST_BYTE;
            enables_q <= `CBT_RST_BYTE;
            presc_q <= `CBT_RST_PRESC;
            init_request_q <= 1'b1;
            init_acknowledge_q <= 1'b0;
            wakeup_enable_q <= 1'b0;
            sleep_q <= 1'b0;
        end else begin
            // Acknowledge follows request one cycle later
            init_acknowledge_q <= init_request_q;
            if (wr_acc && paddr == `CBT_ADDR_CTRL) begin
                init_request_q <= pwdata[`CBT_CTRL_INIT_REQUEST];
                wakeup_enable_q <= pwdata[`CBT_CTRL_WAKEUP_ENABLE];
                sleep_q <= pwdata[`CBT_CTRL_SLEEP];
            end else if (sleep_q && wakeup_enable_q && bus_activity) begin
                sleep_q <= 1'b0;
            end
            if (wr_acc && init_mode && paddr == `CBT_ADDR_TIMING)
                timing_q <= pwdata[7:0];
            if (wr_acc && init_mode && paddr == `CBT_ADDR_PRESC)
                presc_q <= pwdata[5:0];
            if (init_mode)
                enables_q <= `CBT_RST_BYTE;
            else if (wr_acc && paddr == `CBT_ADDR_ENABLES)
                enables_q <= pwdata[7:0];
        end
    end
    // Receiver flags and error states
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wakeup_flag_q <= 1'b0;
            status_change_flag_q <= 1'b0;
            rx_state_q <= `CBT_ST_OK;
            tx_state_q <= `CBT_ST_OK;
        end else begin
            if (init_mode) begin
                wakeup_flag_q <= 1'b0;
                status_change_flag_q <= 1'b0;
            end else begin
                // Set wins over a clear in the same cycle
                if (sleep_q && wakeup_enable_q && bus_activity)
                    wakeup_flag_q <= 1'b1;
                else if (wup_clr)
                    wakeup_flag_q <= 1'b0;
                if (!status_change_flag_q || csc_clr) begin
                    if (rx_state_d != rx_state_q || tx_state_d != tx_state_q)
                        status_change_flag_q <= 1'b1;
                    else
                        status_change_flag_q <= 1'b0;
                end
            end
            // State fields ignore init mode but freeze while flag pends
            if (!status_change_flag_q || csc_clr) begin
                rx_state_q <= rx_state_d;
                tx_state_q <= tx_state_d;
            end
        end
    end
    always @* begin
        rdata_d = 32'h00000000;
        case (paddr)
            `CBT_ADDR_TIMING: rdata_d[7:0] = timing_q;
            `CBT_ADDR_FLAGS: rdata_d[7:0] = {wakeup_flag_q, status_change_flag_q, rx_state_q, tx_state_q, 2'b00};
            `CBT_ADDR_ENABLES: rdata_d[7:0] = enables_q;
            `CBT_ADDR_CTRL: rdata_d[3:0] = {init_acknowledge_q, sleep_q, wakeup_enable_q, init_request_q};
            `CBT_ADDR_PRESC: rdata_d[5:0] = presc_q;
            default: rdata_d = 32'h00000000;
        endcase
    end
    // APB: one wait-free access phase, read data latched in setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            wakeup_irq_q <= 1'b0;
            error_irq_q <= 1'b0;
            rx_bit_q <= 1'b1;
            bit_done_q <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            if (rd_acc)
                prdata <= rdata_d;
            wakeup_irq_q <= wakeup_flag_q && enables_q[`CBT_FLG_WUP];
            error_irq_q <= status_change_flag_q && enables_q[`CBT_FLG_CSC];
            rx_bit_q <= tim_rx_bit;
            bit_done_q <= tim_done;
        end
    end
    cbt_bit_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .run(!init_mode && !sleep_q),
        .presc(presc_q),
        .ts1(timing_q[`CBT_TIM_TS1_HI:`CBT_TIM_TS1_LO]),
        .ts2(timing_q[`CBT_TIM_TS2_HI:`CBT_TIM_TS2_LO]),
        .triple(timing_q[`CBT_TIM_TRIPLE_SAMPLE_SELECT]),
        .rx_sync(rx_sync_q),
        .rx_bit_q(tim_rx_bit),
        .bit_done_q(tim_done)
    );
endmodule // cbt_top

// [sim/cbt_checker.sv]
`timescale 1ns/1ps
module cbt_checker (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire bit_done_q,
    input wire wakeup_irq_q,
    input wire error_irq_q,
    input wire init_acknowledge_q
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    ready_has_cause_a: assert property (pready |-> $past(psel && !penable))
        else $error("ready without setup");
    error_with_ready_a: assert property (pslverr |-> pready)
        else $error("error outside access");
    rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved without read");
    done_pulse_a: assert property (bit_done_q |=> !bit_done_q)
        else $error("bit end longer than one cycle");
    // A bit may still end in the first two cycles after the acknowledge rises
    no_bit_init_a: assert property (init_acknowledge_q && $past(init_acknowledge_q) && $past(init_acknowledge_q, 2) |-> !bit_done_q)
        else $error("bit timer running in init");
    irq_quiet_init_a: assert property (init_acknowledge_q [*3] |-> !wakeup_irq_q && !error_irq_q)
        else $error("request pending in init");
    cover property (error_irq_q);
    cover property (wakeup_irq_q);
    cover property (bit_done_q);
    cover property (pslverr);
endmodule // cbt_checker

bind cbt_top cbt_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bit_done_q(bit_done_q),
    .wakeup_irq_q(wakeup_irq_q), .error_irq_q(error_irq_q), .init_acknowledge_q(init_acknowledge_q));

// [sim/cbt_can_node.sv]
`timescale 1ns/1ps
module cbt_can_node (
    input wire pclk,
    input wire dom,
    output logic can_rx = 1'b1
);
    // Bus idles recessive; a falling edge is activity
    always @(posedge pclk) can_rx <= !dom;
endmodule // cbt_can_node

// [sim/tb.sv]
`timescale 1ns/1ps
`include "cbt_consts.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, dom = 0, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic [8:0] tx_err = 0;
    logic [7:0] rx_err = 0;
    wire [31:0] prdata;
    wire pready, pslverr, can_rx, rx_bit_q, bit_done_q, wakeup_irq_q, error_irq_q, init_acknowledge_q;
    int n_errors = 0, total_checks = 0, cyc = 0, t1, t2, p, n;
    int tbl[6][2] = '{'{100, 0}, '{130, 0}, '{130, 100}, '{130, 200}, '{0, 300}, '{0, 0}};
    always #5 pclk = ~pclk;
    cbt_can_node u_node (.pclk(pclk), .dom(dom), .can_rx(can_rx));
    cbt_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .can_rx(can_rx), .tx_err_count(tx_err), .rx_err_count(rx_err), .rx_bit_q(rx_bit_q),
        .bit_done_q(bit_done_q), .wakeup_irq_q(wakeup_irq_q), .error_irq_q(error_irq_q),
        .init_acknowledge_q(init_acknowledge_q));
    function automatic int st(int c, int t);
        return t > 255 ? 3 : c > 127 ? 2 : c > 96 ? 1 : 0;
    endfunction
    task results;
        if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task apb(input bit w, input [11:0] a, input [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task rchk(input [11:0] a, input [7:0] e);
        apb(0, a, 0);
        `CHK($sformatf("reg_%h", a), 32'(e), rd)
    endtask
    task fchk(input int c);
        rchk(`CBT_ADDR_FLAGS, 8'(c * 64 + st(rx_err, tx_err) * 16 + st(tx_err, tx_err) * 4));
    endtask
    // Counters are levels; give the flag logic a few cycles to see them
    task cnt(input int r, input int t);
        @(posedge pclk);
        rx_err <= 8'(r);
        tx_err <= 9'(t);
        repeat (4) @(posedge pclk);
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            results();
        end
    end
    initial begin
        void'($urandom(54471));
        repeat (4) @(posedge pclk);
        presetn <= 1;
        repeat (3) @(posedge pclk);
        rchk(`CBT_ADDR_CTRL, 8'h09);
        rchk(`CBT_ADDR_TIMING, 8'h00);
        apb(1, 12'h020, 32'hFF);
        `CHK("slverr", 1'b1, err)
        apb(1, `CBT_ADDR_FLAGS, 32'hFF);
        apb(1, `CBT_ADDR_ENABLES, 32'hC0);
        rchk(`CBT_ADDR_FLAGS, 8'h00);
        rchk(`CBT_ADDR_ENABLES, 8'h00);
        for (int s = 0; s < 2; s++) begin
            t1 = 3 + $urandom % 13;
            t2 = 1 + $urandom % 7;
            p = $urandom % 4;
            apb(1, `CBT_ADDR_CTRL, 1);
            apb(1, `CBT_ADDR_PRESC, p);
            apb(1, `CBT_ADDR_TIMING, s * 128 + t2 * 16 + t1);
            apb(1, `CBT_ADDR_CTRL, 0);
            // Opposite level per pass, so each sampling mode must move the bit
            dom <= 1'(1 - s);
            apb(1, `CBT_ADDR_TIMING, 0);
            rchk(`CBT_ADDR_TIMING, 8'(s * 128 + t2 * 16 + t1));
            n = 0;
            @(posedge pclk iff bit_done_q);
            do begin @(posedge pclk); n++; end while (bit_done_q !== 1'b1);
            `CHK("bit_time", (p + 1) * (3 + t1 + t2), n)
            `CHK("rx_bit", !dom, rx_bit_q)
        end
        dom <= 0;
        apb(1, `CBT_ADDR_ENABLES, 32'hC0);
        rchk(`CBT_ADDR_ENABLES, 8'hC0);
        apb(1, `CBT_ADDR_CTRL, 32'h06);
        dom <= 1;
        // Edge needs the node flop, two sync flops and the edge detector
        repeat (5) @(posedge pclk);
        rchk(`CBT_ADDR_FLAGS, 8'h80);
        `CHK("wake_irq", 1'b1, wakeup_irq_q)
        dom <= 0;
        apb(1, `CBT_ADDR_FLAGS, 32'h80);
        rchk(`CBT_ADDR_FLAGS, 8'h00);
        foreach (tbl[i]) begin
            cnt(tbl[i][0], tbl[i][1]);
            fchk(1);
            `CHK("err_irq", 1'b1, error_irq_q)
            apb(1, `CBT_ADDR_FLAGS, 32'h40);
            fchk(0);
            `CHK("err_irq", 1'b0, error_irq_q)
        end
        cnt(100, 0);
        cnt(130, 0);
        rchk(`CBT_ADDR_FLAGS, 8'h50);
        apb(1, `CBT_ADDR_FLAGS, 32'h3C);
        rchk(`CBT_ADDR_FLAGS, 8'h50);
        apb(1, `CBT_ADDR_FLAGS, 32'h40);
        rchk(`CBT_ADDR_FLAGS, 8'h60);
        apb(1, `CBT_ADDR_CTRL, 1);
        // Init mode needs the acknowledge cycle before flags are held
        repeat (2) @(posedge pclk);
        rchk(`CBT_ADDR_FLAGS, 8'h20);
        `CHK("init_ack", 1'b1, init_acknowledge_q)
        rchk(`CBT_ADDR_ENABLES, 8'h00);
        results();
    end
endmodule // tb
